/* File: compact_timer_unit.sv */
/*
  Compact 10-bit timer with compare-match output, PWM and timer modes,
  reached as an AHB-Lite slave. Holds the registers, the sticky match flags
  and the output pin logic; counting lives in count_compare_core.
  Assumes a single AHB-Lite master on hclk and an external count pin
  that is asynchronous to hclk.
*/
`timescale 1ns/1ps
`default_nettype none

module compact_timer_unit #(
  parameter int DEC_W = compact_timer_pkg::DEC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_count_pin,
  output logic timer_output_pin,
  output logic timer_output_pin_oe_n,
  output logic match_a_flag,
  output logic match_p_flag
);
  import compact_timer_pkg::*;

  // decode must at least reach the highest offset
  if (DEC_W < 5 || DEC_W > 12) begin : g_bad_dec
    $error("compact_timer_unit decode width must be 5 to 12 bits");
  end

  core_link_if lnk ();

  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic [7:0] run_ctrl_q;
  logic [7:0] timer_mode_output_control_q;
  logic [9:0] cmp_a_q;
  logic [1:0] flags_q;
  logic dph_valid_q;
  logic dph_write_q;
  logic [11:0] dph_addr_q;
  logic [31:0] rdata_q;
  logic pin_q;
  logic pin_out_q;
  logic oe_n_q;
  logic accept;
  logic wr_en;
  logic [11:0] aph_addr;
  logic [31:0] rd_word;
  logic [1:0] mode_sel;
  logic [1:0] pin_action;
  logic initial_level;
  logic output_invert;
  logic [1:0] flag_clr;
  logic level_d;
  logic drive_d;

  // ****************************************
  // external count pin synchroniser
  // ****************************************
  // first stage feeds the second only; edges come from later stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_count_pin;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // ****************************************
  // control field unpacking
  // ****************************************
  assign mode_sel = timer_mode_output_control_q[MODE_LSB +: 2];
  assign pin_action = timer_mode_output_control_q[IO_LSB +: 2];
  assign initial_level = timer_mode_output_control_q[OC_BIT];
  assign output_invert = timer_mode_output_control_q[POL_BIT];

  // core hookup
  assign lnk.mode_sel = mode_sel;
  assign lnk.clear_source = timer_mode_output_control_q[CCLR_BIT];
  assign lnk.duty_period_swap = timer_mode_output_control_q[DPX_BIT];
  assign lnk.counter_on = run_ctrl_q[ON_BIT];
  assign lnk.pause = run_ctrl_q[PAUSE_BIT];
  assign lnk.clk_sel = run_ctrl_q[CLK_LSB +: 3];
  assign lnk.compare_a_value = cmp_a_q;
  assign lnk.compare_p_value = run_ctrl_q[RP_LSB +: 3];
  assign lnk.ext_rise = ext_sync_q & ~ext_prev_q;
  assign lnk.ext_fall = ~ext_sync_q & ext_prev_q;

  count_compare_core #(
    .CNT_W(CNT_W)
  ) u_core (
    .hclk(hclk),
    .hresetn(hresetn),
    .lnk(lnk)
  );

  // ****************************************
  // AHB-Lite slave: address and data phase
  // ****************************************
  // zero wait states, so the slave never stalls and always answers okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign accept = hsel & htrans[1] & hready;
  assign aph_addr = 12'(haddr[DEC_W-1:0]);
  // only whole-word writes land; narrower ones are dropped quietly
  assign wr_en = dph_valid_q & dph_write_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_valid_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_addr_q <= 12'h000;
    end else begin
      dph_valid_q <= accept;
      if (accept) begin
        dph_write_q <= hwrite & (hsize == HSIZE_WORD);
        dph_addr_q <= aph_addr;
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (aph_addr)
      OFF_RUN_CTRL: rd_word[7:0] = run_ctrl_q;
      OFF_MODE_CTRL: rd_word[7:0] = timer_mode_output_control_q;
      OFF_COUNT: rd_word[9:0] = lnk.count;
      OFF_CMP_A: rd_word[9:0] = cmp_a_q;
      OFF_FLAGS: rd_word[1:0] = flags_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data sampled at the address phase, presented in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      rdata_q <= rd_word;
    end
  end
  assign hrdata = rdata_q;

  // ****************************************
  // software registers
  // ****************************************
  // pin action changes while running are taken as written; keeping
  // them static during pwm is left to software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ctrl_q <= RUN_CTRL_RST;
      timer_mode_output_control_q <= MODE_CTRL_RST;
      cmp_a_q <= CMP_A_RST;
    end else if (wr_en) begin
      if (dph_addr_q == OFF_RUN_CTRL) begin
        run_ctrl_q <= hwdata[7:0];
      end
      if (dph_addr_q == OFF_MODE_CTRL) begin
        timer_mode_output_control_q <= hwdata[7:0];
      end
      if (dph_addr_q == OFF_CMP_A) begin
        cmp_a_q <= hwdata[9:0];
      end
    end
  end

  // ****************************************
  // sticky match flags
  // ****************************************
  // write one to clear; a match in the same cycle wins so none is lost
  assign flag_clr = (wr_en && dph_addr_q == OFF_FLAGS) ? hwdata[1:0] : 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= 2'h0;
    end else begin
      flags_q[FLAG_A_BIT] <= lnk.match_a | (flags_q[FLAG_A_BIT] & ~flag_clr[FLAG_A_BIT]);
      flags_q[FLAG_P_BIT] <= lnk.match_p | (flags_q[FLAG_P_BIT] & ~flag_clr[FLAG_P_BIT]);
    end
  end
  assign match_a_flag = flags_q[FLAG_A_BIT];
  assign match_p_flag = flags_q[FLAG_P_BIT];

  // ****************************************
  // compare-mode pin state
  // ****************************************
  // only the start and A matches move the pin; a requested level equal to the
  // present one naturally leaves it unchanged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 1'b0;
    end else if (lnk.on_rise) begin
      pin_q <= initial_level;
    end else if (mode_sel == MODE_CMP && lnk.match_a) begin
      unique case (pin_action)
        IO_HOLD: pin_q <= pin_q;
        IO_LOW: pin_q <= 1'b0;
        IO_HIGH: pin_q <= 1'b1;
        IO_TOGGLE: pin_q <= ~pin_q;
      endcase
    end
  end

  // ****************************************
  // pin level selection
  // ****************************************
  // pwm active level is the initial-level bit; undefined action stays inactive
  always_comb begin
    level_d = 1'b0;
    drive_d = 1'b0;
    unique case (mode_sel)
      MODE_CMP: begin
        level_d = pin_q;
        drive_d = 1'b1;
      end
      MODE_PWM: begin
        drive_d = 1'b1;
        unique case (pin_action)
          IO_LOW: level_d = initial_level;
          IO_HIGH: level_d = lnk.pwm_active ? initial_level : ~initial_level;
          default: level_d = ~initial_level;
        endcase
      end
      default: begin
        level_d = 1'b0;
        drive_d = 1'b0;
      end
    endcase
  end

  // registered pin; timer mode and the unused mode code release it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      pin_out_q <= drive_d & (level_d ^ output_invert);
      oe_n_q <= ~drive_d;
    end
  end
  assign timer_output_pin = pin_out_q;
  assign timer_output_pin_oe_n = oe_n_q;

  // ****************************************
  // checks
  // ****************************************
  a_flag_stays: assert property (@(posedge hclk) disable iff (!hresetn)
    (flags_q[FLAG_A_BIT] && !flag_clr[FLAG_A_BIT]) |=> flags_q[FLAG_A_BIT])
    else $error("a flag dropped without clear");
  a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    lnk.match_p |=> flags_q[FLAG_P_BIT]) else $error("p match lost");
  a_cmp_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_sel == MODE_CMP && pin_action == IO_TOGGLE && lnk.match_a && !lnk.on_rise)
    |=> (pin_q != $past(pin_q))) else $error("toggle missed");
  a_cmp_low_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_sel == MODE_CMP && pin_action == IO_LOW && lnk.match_a && !lnk.on_rise)
    ##1 (mode_sel == MODE_CMP && !output_invert) |=> !timer_output_pin)
    else $error("low action did not reach pin");
  a_init_level: assert property (@(posedge hclk) disable iff (!hresetn)
    lnk.on_rise |=> (pin_q == $past(initial_level))) else $error("initial level missed");
  a_timer_free: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_sel == MODE_TMR) |=> timer_output_pin_oe_n) else $error("pin driven in timer mode");
  a_pwm_forced: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_sel == MODE_PWM && pin_action == IO_LOW) |=>
    (timer_output_pin == ($past(initial_level) ^ $past(output_invert))))
    else $error("forced active level wrong");
  a_p_no_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_sel == MODE_CMP && lnk.match_p && !lnk.match_a && !lnk.on_rise)
    |=> $stable(pin_q)) else $error("p match moved pin");

endmodule // compact_timer_unit

`default_nettype wire

/* File: compact_timer_pkg.sv */
/*
  Shared constants for the compact 10-bit timer: register offsets, field
  positions, reset values, mode and pin-action codes, and the period helper.
  Assumes a 32-bit AHB-Lite bus with one register per aligned word.
*/
`default_nettype none

package compact_timer_pkg;

  // ****************************************
  // widths and counter limits
  // ****************************************
  localparam int CNT_W = 10;
  localparam int RP_W = 3;
  localparam int DEC_W = 12;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam logic [10:0] PERIOD_FULL = 11'h400;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFF_RUN_CTRL = 12'h000;
  localparam logic [11:0] OFF_MODE_CTRL = 12'h004;
  localparam logic [11:0] OFF_COUNT = 12'h008;
  localparam logic [11:0] OFF_CMP_A = 12'h00C;
  localparam logic [11:0] OFF_FLAGS = 12'h010;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int PAUSE_BIT = 7;
  localparam int CLK_LSB = 4;
  localparam int ON_BIT = 3;
  localparam int RP_LSB = 0;
  localparam int MODE_LSB = 6;
  localparam int IO_LSB = 4;
  localparam int OC_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int DPX_BIT = 1;
  localparam int CCLR_BIT = 0;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam logic [7:0] RUN_CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [9:0] CMP_A_RST = 10'h000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************
  // mode, pin action and clock select codes
  // ****************************************
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] IO_HOLD = 2'h0;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [2:0] CLK_DIV4 = 3'h0;
  localparam logic [2:0] CLK_DIV1 = 3'h1;
  localparam logic [2:0] CLK_DIV16 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h3;
  localparam logic [2:0] CLK_SLOW0 = 3'h4;
  localparam logic [2:0] CLK_SLOW1 = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;

  // 3-bit code in 128-clock steps, zero meaning the full 1024
  function automatic logic [10:0] period_code(input logic [2:0] rp);
    return (rp == 3'h0) ? PERIOD_FULL : {1'b0, rp, 7'h00};
  endfunction

endpackage

`default_nettype wire

/* File: core_link_if.sv */
/*
  Carrier between the register side of the timer and its counting core.
  Assumes both ends run on the same bus clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface core_link_if;
  logic [1:0] mode_sel;
  logic clear_source;
  logic duty_period_swap;
  logic counter_on;
  logic pause;
  logic [2:0] clk_sel;
  logic [9:0] compare_a_value;
  logic [2:0] compare_p_value;
  logic ext_rise;
  logic ext_fall;
  logic [9:0] count;
  logic match_a;
  logic match_p;
  logic pwm_active;
  logic on_rise;

  modport core (input mode_sel, clear_source, duty_period_swap, counter_on, pause, clk_sel,
    compare_a_value, compare_p_value, ext_rise, ext_fall,
    output count, match_a, match_p, pwm_active, on_rise);
  modport ctrl (output mode_sel, clear_source, duty_period_swap, counter_on, pause, clk_sel,
    compare_a_value, compare_p_value, ext_rise, ext_fall,
    input count, match_a, match_p, pwm_active, on_rise);
endinterface

`default_nettype wire

/* File: count_compare_core.sv */
/*
  Counting core: prescaler, 10-bit up counter, both comparators, clear
  selection and the PWM active window. Match outputs are one-cycle pulses.
  Assumes control fields come from registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module count_compare_core #(
  parameter int CNT_W = compact_timer_pkg::CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  core_link_if.core lnk
);
  import compact_timer_pkg::*;

  logic [7:0] div_q;
  logic on_prev_q;
  logic [9:0] cnt_q;
  logic tick;
  logic run;
  logic pwm;
  logic [10:0] cnt_next;
  logic [10:0] rp_val;
  logic [10:0] period_val;
  logic [10:0] duty_val;
  logic hit_a;
  logic hit_p;
  logic clr;

  // the comparator layout is fixed to a 10-bit counter
  if (CNT_W != 10) begin : g_bad_width
    $error("count_compare_core supports only a 10-bit counter");
  end

  // ****************************************
  // prescaler and tick selection
  // ****************************************
  // free-running divider; slow taps stand in for the sub clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_comb begin
    unique case (lnk.clk_sel)
      CLK_DIV4: tick = &div_q[1:0];
      CLK_DIV1: tick = 1'b1;
      CLK_DIV16: tick = &div_q[3:0];
      CLK_DIV64: tick = &div_q[5:0];
      CLK_SLOW0, CLK_SLOW1: tick = &div_q;
      CLK_EXT_RISE: tick = lnk.ext_rise;
      CLK_EXT_FALL: tick = lnk.ext_fall;
    endcase
  end

  // ****************************************
  // compare and clear decisions
  // ****************************************
  assign lnk.on_rise = lnk.counter_on & ~on_prev_q;
  assign run = tick & lnk.counter_on & ~lnk.pause & ~lnk.on_rise;
  assign pwm = (lnk.mode_sel == MODE_PWM);
  assign cnt_next = {1'b0, cnt_q} + 11'h001;
  // P sees only the top three bits, so its match points are 128-clock steps
  assign rp_val = period_code(lnk.compare_p_value);
  assign hit_a = (cnt_next == {1'b0, lnk.compare_a_value});
  assign hit_p = (cnt_next == rp_val);
  // a zero A period in swapped PWM falls back to the full count
  assign period_val = lnk.duty_period_swap ?
    ((lnk.compare_a_value == 10'h000) ? PERIOD_FULL : {1'b0, lnk.compare_a_value}) : rp_val;
  assign duty_val = lnk.duty_period_swap ? rp_val : {1'b0, lnk.compare_a_value};
  // pwm ignores the clear source; the period register alone clears
  assign clr = pwm ? (cnt_next == period_val) :
    (lnk.clear_source ? hit_a : hit_p);
  assign lnk.match_a = run & hit_a;
  assign lnk.match_p = run & hit_p & (pwm | ~lnk.clear_source);
  // duty at or above period keeps the window open all period, even if a
  // residual count above the period is left over from a shorter setting
  assign lnk.pwm_active = (duty_val >= period_val) | ({1'b0, cnt_q} < duty_val);
  assign lnk.count = cnt_q;

  // ****************************************
  // counter
  // ****************************************
  // counting goes on whatever the pin action; overflow wraps by width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_prev_q <= 1'b0;
      cnt_q <= 10'h000;
    end else begin
      on_prev_q <= lnk.counter_on;
      if (lnk.on_rise) begin
        cnt_q <= 10'h000;
      end else if (run) begin
        cnt_q <= clr ? 10'h000 : cnt_next[9:0];
      end
    end
  end

  a_no_p_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pwm && lnk.clear_source) |-> !lnk.match_p) else $error("p flag raised with A clear");
  a_on_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    lnk.on_rise |=> (cnt_q == 10'h000)) else $error("counter not zeroed on start");
  a_off_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    !lnk.counter_on |=> $stable(cnt_q)) else $error("counter moved while off");
  a_p_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pwm && !lnk.clear_source && lnk.match_p) |=> (cnt_q == 10'h000))
    else $error("p match did not clear counter");
  a_full_duty: assert property (@(posedge hclk) disable iff (!hresetn)
    (pwm && duty_val >= period_val) |-> lnk.pwm_active) else $error("full duty broke");

endmodule // count_compare_core

`default_nettype wire

/* File: pin_load.sv */
/*
  External load on the timer output pin: resolves the pin level.
  Assumes oe_n low while the timer drives the pin, pull-down otherwise.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_load (
  input wire logic pin,
  input wire logic oe_n,
  output logic line
);
  // pull-down takes the line low once the timer lets go, never the old level
  assign line = oe_n ? 1'b0 : pin;
endmodule // pin_load

`default_nettype wire

/* File: testbench.sv */
/*
  Self-checking bench for the compact timer: AHB-Lite master tasks,
  compare and pwm scenarios judged on the resolved pin line, timer scenarios on the count and flags.
  Assumes hclk counting (select 001) outside the external-pin test, and a pulled-down output line.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import compact_timer_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ext_count_pin = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin, pin_oe_n, flag_a, flag_p, line;
  int failures = 0;
  int check_count = 0;

  compact_timer_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_count_pin(ext_count_pin),
    .timer_output_pin(pin), .timer_output_pin_oe_n(pin_oe_n), .match_a_flag(flag_a),
    .match_p_flag(flag_p));
  pin_load load (.pin(pin), .oe_n(pin_oe_n), .line(line));

  // 25 MHz bus clock
  always #20 hclk = ~hclk;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hung(input int n, input int lim);
    if (n >= lim) begin
      chk("wait bound", 32'h0000_0001, 32'h0000_0000);
      give_verdict();
    end
  endtask

  // one single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hung(n, 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hung(n, 50);
    rd = hrdata;
    chk("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  task automatic wflag(input logic p, input int lim);
    int n;
    n = 0;
    while ((p ? flag_p : flag_a) !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
    hung(n, lim);
  endtask

  // stop, set up, clear flags, restart: pin action changes only while off
  task automatic start(input logic [7:0] mc, input logic [9:0] a, input logic [2:0] p);
    bus(1'b1, OFF_RUN_CTRL, {24'h00_0000, 1'b0, CLK_DIV1, 1'b0, p});
    bus(1'b1, OFF_MODE_CTRL, {24'h00_0000, mc});
    bus(1'b1, OFF_CMP_A, {22'h00_0000, a});
    bus(1'b1, OFF_FLAGS, 32'h0000_0003);
    bus(1'b1, OFF_RUN_CTRL, {24'h00_0000, 1'b0, CLK_DIV1, 1'b1, p});
    repeat (3) @(posedge hclk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [11:0] offs [5] = '{OFF_RUN_CTRL, OFF_MODE_CTRL, OFF_COUNT, OFF_CMP_A, OFF_FLAGS};
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0000_0000);
      chk("reset value", rd, 32'h0000_0000);
    end
    bus(1'b1, 12'h020, 32'hFFFF_FFFF);
    bus(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    bus(1'b1, OFF_CMP_A, 32'hFFFF_FFFF);
    bus(1'b0, OFF_CMP_A, 32'h0000_0000);
    chk("compare a rw", rd, 32'h0000_03FF);
    $display("test regs done");
  endtask

  // every pin action, initial level and polarity; A period 200, P at 128
  task automatic t_compare;
    logic e;
    for (int c = 0; c < 16; c++) begin
      start({MODE_CMP, c[3:2], c[1], c[0], 2'b01}, 10'h0C8, 3'h1);
      chk("initial level", line, c[1] ^ c[0]);
      chk("oe_n", pin_oe_n, 1'b0);
      wflag(1'b0, 300);
      repeat (3) @(posedge hclk);
      e = (c[3:2] == IO_HOLD) ? c[1] : (c[3:2] == IO_TOGGLE) ? !c[1] : c[3];
      chk("match level", line, e ^ c[0]);
      chk("no p flag", flag_p, 1'b0);
    end
    $display("test compare done");
  endtask

  task automatic t_clear;
    for (int m = 0; m < 2; m++) begin
      start({m ? MODE_TMR : MODE_CMP, IO_HIGH, 4'b0000}, 10'h032, 3'h1);
      wflag(1'b1, 300);
      chk("a flag", flag_a, 1'b1);
      chk("oe_n mode", pin_oe_n, m[0]);
      bus(1'b0, OFF_COUNT, 32'h0000_0000);
      chk("p clears", rd < 32'h0000_0080, 1'b1);
    end
    start({MODE_CMP, IO_HOLD, 4'b0001}, 10'h000, 3'h0);
    repeat (1100) @(posedge hclk);
    chk("no a flag", flag_a, 1'b0);
    bus(1'b0, OFF_COUNT, 32'h0000_0000);
    chk("wrapped", rd < 32'h0000_0100, 1'b1);
    $display("test clear done");
  endtask

  task automatic pwm(input logic [7:0] mc, input logic [9:0] a, input logic [2:0] p,
                     input int win, input int exp);
    int n;
    start(mc, a, p);
    repeat (win + 10) @(posedge hclk);
    n = 0;
    repeat (win) begin
      @(posedge hclk);
      n += line;
    end
    chk("pwm high", n, exp);
  endtask

  task automatic t_pwm;
    pwm({MODE_PWM, IO_HIGH, 4'b1001}, 10'h020, 3'h1, 128, 32);
    pwm({MODE_PWM, IO_HIGH, 4'b1000}, 10'h0C8, 3'h1, 128, 128);
    pwm({MODE_PWM, IO_HIGH, 4'b0000}, 10'h020, 3'h1, 128, 96);
    pwm({MODE_PWM, IO_HIGH, 4'b1100}, 10'h020, 3'h1, 128, 96);
    pwm({MODE_PWM, IO_LOW, 4'b1000}, 10'h020, 3'h1, 128, 128);
    pwm({MODE_PWM, IO_HOLD, 4'b1000}, 10'h020, 3'h1, 128, 0);
    chk("pwm flags", {flag_a, flag_p}, 2'b11);
    pwm({MODE_PWM, IO_HIGH, 4'b1010}, 10'h100, 3'h1, 256, 128);
    $display("test pwm done");
  endtask

  // k pulses on the external count pin, then time for the synchroniser
  task automatic pulses(input int k);
    repeat (k) begin
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
  endtask

  // external edges count in timer mode; off and pause hold the count
  task automatic t_ext;
    logic [31:0] base;
    start({MODE_TMR, IO_HOLD, 4'b0001}, 10'h000, 3'h0);
    bus(1'b1, OFF_RUN_CTRL, {24'h00_0000, 1'b0, CLK_EXT_RISE, 1'b1, 3'h0});
    bus(1'b0, OFF_COUNT, 32'h0000_0000);
    base = rd;
    pulses(5);
    bus(1'b0, OFF_COUNT, 32'h0000_0000);
    chk("rise count", rd, base + 32'h0000_0005);
    bus(1'b1, OFF_RUN_CTRL, {24'h00_0000, 1'b0, CLK_EXT_RISE, 1'b0, 3'h0});
    pulses(3);
    bus(1'b0, OFF_COUNT, 32'h0000_0000);
    chk("off holds", rd, base + 32'h0000_0005);
    bus(1'b1, OFF_RUN_CTRL, {24'h00_0000, 1'b1, CLK_EXT_FALL, 1'b1, 3'h0});
    pulses(3);
    bus(1'b0, OFF_COUNT, 32'h0000_0000);
    chk("paused at zero", rd, 32'h0000_0000);
    bus(1'b1, OFF_RUN_CTRL, {24'h00_0000, 1'b0, CLK_EXT_FALL, 1'b1, 3'h0});
    pulses(2);
    bus(1'b0, OFF_COUNT, 32'h0000_0000);
    chk("fall count", rd, 32'h0000_0002);
    $display("test ext done");
  endtask

  // main sequence with reset held two cycles
  initial begin
    repeat (2) @(posedge hclk);
    chk("reset oe_n", pin_oe_n, 1'b1);
    chk("reset flags", {flag_a, flag_p}, 2'b00);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_compare();
    t_clear();
    t_pwm();
    t_ext();
    give_verdict();
  end

  // overall bound against a hang anywhere
  initial begin
    repeat (60000) @(posedge hclk);
    chk("run bound", 32'h0000_0001, 32'h0000_0000);
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
